// *** logic/isf_pkg.sv ***
// Package for the two-wire bus status-flag block: register map, field
// positions, reset values and the flag record carried between processes.
// Assumes a 32-bit AHB-Lite slave port with one register per aligned word.
package isf_pkg;

    // Register byte offsets
    localparam logic [7:0] STAT_OFS   = 8'h00; // Status flags, write one to clear sticky bits
    localparam logic [7:0] TXH_OFS    = 8'h04; // Transmit holding, write only
    localparam logic [7:0] RXH_OFS    = 8'h08; // Receive holding, read only
    localparam logic [7:0] IRQ_ST_OFS = 8'h0c; // Sticky event status
    localparam logic [7:0] IRQ_CL_OFS = 8'h10; // Write one to clear events
    localparam logic [7:0] IRQ_EN_OFS = 8'h14; // Event enables

    // Status field positions
    localparam int ACK_POS  = 15;
    localparam int TIP_POS  = 14;
    localparam int BCL_POS  = 10;
    localparam int GC_POS   = 9;
    localparam int T10_POS  = 8;
    localparam int WCOL_POS = 7;
    localparam int OVF_POS  = 6;
    localparam int DA_POS   = 5;
    localparam int STP_POS  = 4;

    // Interrupt event positions
    localparam int EV_ACK  = 0; // Acknowledge slot finished
    localparam int EV_BCL  = 1; // Bus collision
    localparam int EV_WCOL = 2; // Write collision
    localparam int EV_OVF  = 3; // Receive overflow
    localparam int EV_STOP = 4; // Stop seen
    localparam int EV_W    = 5;

    // Values after reset and counts
    localparam logic [EV_W-1:0] IRQ_RST  = 5'h00;
    localparam logic [7:0]      BYTE_RST = 8'h00;
    localparam logic [3:0]      ACK_EDGE = 4'h9; // SCL rise that carries ACK

    // Status flags
    typedef struct packed {
        logic ack_result_flag;
        logic transmit_in_progress;
        logic bus_collision_flag;
        logic general_call_flag;
        logic ten_bit_match_flag;
        logic write_collision_flag;
        logic receive_overflow_flag;
        logic data_not_addr;
        logic stop_last;
    } isf_flags_t;

    localparam isf_flags_t FLAGS_RST = '0;

endpackage

// *** logic/isf_status.sv ***
// Status-flag logic of a two-wire bus controller with an AHB-Lite slave port.
// Assumes the byte engine on the same clock pulses its events, and that the
// bus pins arrive asynchronously and are synchronised here.
// How it works
// R1 - ACK flag updated after each ACK slot
// R2 - Transmit flag spans eight bits plus ACK
// R3 - Status bits 13 to 11 read zero
// R4 - Collision during master operation sets flag
// R5 - General call match sets, Stop clears
// R6 - Ten-bit second byte match sets, Stop clears
// R7 - Busy transmit write fails, sets collision flag
// R8 - Overflow when receive holding still full
// R9 - Address match clears, slave data sets
// R10 - Stop-last tracks latest Start or Stop
// R11 - All flags zero after reset
// R12 - Software clears collision before next operation
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module isf_status
    import isf_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Bus pins, asynchronous
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // Byte engine events, same clock
    input  wire logic        engine_busy_in,
    input  wire logic        master_op_in,
    input  wire logic        collision_in,
    input  wire logic        gen_call_match_in,
    input  wire logic        ten_bit_match_in,
    input  wire logic        addr_match_in,
    input  wire logic        slave_data_rx_in,
    input  wire logic        rx_xfer_in,
    input  wire logic [7:0]  rx_shift_reg_in,
    // Transmit hand-off and interrupt
    output logic      [7:0]  tx_data_out,
    output logic             tx_load_out,
    output logic             irq_out
);

    // Pin synchronisers; first stages feed only the second stages
    logic       scl_meta;       // SCL first stage
    logic       scl_sync;       // SCL second stage
    logic       scl_prev;       // SCL one cycle older
    logic       sda_meta;       // SDA first stage
    logic       sda_sync;       // SDA second stage
    logic       sda_prev;       // SDA one cycle older
    logic       scl_rise;       // SCL rising edge seen
    logic       scl_fall;       // SCL falling edge seen
    logic       start_det;      // Start or Repeated Start
    logic       stop_det;       // Stop

    // Master transmit tracking
    logic [3:0] edge_cnt;       // SCL rises within the byte
    logic [3:0] next_edge_cnt;
    logic       ack_seen;       // SDA level caught on the ACK rise
    logic       next_ack_seen;
    logic       ack_done;       // ACK slot ended this cycle

    // Flags and holding registers
    isf_flags_t       flags;
    isf_flags_t       next_flags;
    logic [7:0]       tx_holding_reg;
    logic [7:0]       next_tx_holding_reg;
    logic [7:0]       rx_holding_reg;
    logic [7:0]       next_rx_holding_reg;
    logic             rx_full;          // Receive holding not yet read
    logic             next_rx_full;
    logic             next_tx_load;

    // Interrupt state
    logic [EV_W-1:0]  irq_stat;
    logic [EV_W-1:0]  next_irq_stat;
    logic [EV_W-1:0]  irq_en;
    logic [EV_W-1:0]  next_irq_en;
    logic [EV_W-1:0]  events;
    logic             next_irq;

    // Bus slave state
    logic             wr_pend;          // Write data phase pending
    logic             next_wr_pend;
    logic [7:0]       wr_addr;          // Offset of the pending write
    logic [7:0]       next_wr_addr;
    logic [31:0]      next_hrdata;
    logic             addr_ok;          // Valid address phase
    logic             rd_now;
    logic             wr_data;          // Write data on hwdata now
    logic             tx_wr;
    logic             stat_wr;

    // Status word with unimplemented bits as zero
    function automatic logic [31:0] stat_word(input isf_flags_t f);
        logic [31:0] w;
        w = 32'h0000_0000;                               // [R3]
        w[ACK_POS]  = f.ack_result_flag;
        w[TIP_POS]  = f.transmit_in_progress;
        w[BCL_POS]  = f.bus_collision_flag;
        w[GC_POS]   = f.general_call_flag;
        w[T10_POS]  = f.ten_bit_match_flag;
        w[WCOL_POS] = f.write_collision_flag;
        w[OVF_POS]  = f.receive_overflow_flag;
        w[DA_POS]   = f.data_not_addr;
        w[STP_POS]  = f.stop_last;
        return w;
    endfunction

    // Pin sampling, plain shift chain
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            {scl_meta, scl_sync, scl_prev} <= 3'h7;
            {sda_meta, sda_sync, sda_prev} <= 3'h7;
        end else begin
            {scl_meta, scl_sync, scl_prev} <= {scl_in, scl_meta, scl_sync};
            {sda_meta, sda_sync, sda_prev} <= {sda_in, sda_meta, sda_sync};
        end
    end

    // Line conditions from synchronised levels only
    always_comb begin
        scl_rise  = scl_sync & ~scl_prev;
        scl_fall  = ~scl_sync & scl_prev;
        start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
        stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync;
    end

    // Bit counter: the ninth rise is the ACK; the slot ends at the next fall
    always_comb begin
        next_edge_cnt = edge_cnt;
        next_ack_seen = ack_seen;
        ack_done      = 1'b0;
        if (start_det || stop_det || tx_load_out) begin
            next_edge_cnt = 4'h0;                       // New byte framing
        end else if (scl_rise && edge_cnt != ACK_EDGE) begin
            next_edge_cnt = edge_cnt + 4'h1;
            if (edge_cnt + 4'h1 == ACK_EDGE) begin
                next_ack_seen = sda_sync;               // High means NACK
            end
        end else if (scl_fall && edge_cnt == ACK_EDGE) begin
            ack_done      = 1'b1;                       // End of ACK slot
            next_edge_cnt = 4'h0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            edge_cnt <= 4'h0;
            ack_seen <= 1'b0;
        end else begin
            edge_cnt <= next_edge_cnt;
            ack_seen <= next_ack_seen;
        end
    end

    // Bus decode; zero wait states, so hready is always ours
    always_comb begin
        addr_ok  = hsel_in & htrans_in[1] & hready_in;
        rd_now   = addr_ok & ~hwrite_in;
        wr_data  = wr_pend;
        tx_wr    = wr_data && wr_addr == TXH_OFS;
        stat_wr  = wr_data && wr_addr == STAT_OFS;
        next_wr_pend = addr_ok & hwrite_in;
        next_wr_addr = haddr_in[7:0];
        next_hrdata  = 32'h0000_0000;                   // Unmapped reads zero
        if (rd_now) begin
            unique case (haddr_in[7:0])
                STAT_OFS:   next_hrdata = stat_word(flags);
                RXH_OFS:    next_hrdata = {24'h00_0000, rx_holding_reg};
                IRQ_ST_OFS: next_hrdata = {27'h000_0000, irq_stat};
                IRQ_EN_OFS: next_hrdata = {27'h000_0000, irq_en};
                default:    next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Flag updates; where set and clear meet, set wins
    always_comb begin
        next_flags          = flags;
        next_tx_holding_reg = tx_holding_reg;
        next_rx_holding_reg = rx_holding_reg;
        next_rx_full        = rx_full;
        next_tx_load        = 1'b0;
        // Software clears sticky bits by writing one to the status word
        if (stat_wr) begin
            if (hwdata_in[BCL_POS])  next_flags.bus_collision_flag    = 1'b0; // [R12]
            if (hwdata_in[WCOL_POS]) next_flags.write_collision_flag  = 1'b0; // [R7]
            if (hwdata_in[OVF_POS])  next_flags.receive_overflow_flag = 1'b0; // [R8]
        end
        // Reading the receive holding frees it
        if (rd_now && haddr_in[7:0] == RXH_OFS) begin
            next_rx_full = 1'b0;
        end
        // Transmit write: refused while busy, else starts a master byte
        if (tx_wr) begin
            if (engine_busy_in || flags.transmit_in_progress) begin
                next_flags.write_collision_flag = 1'b1;        // [R7]
            end else begin
                next_tx_holding_reg = hwdata_in[7:0];
                next_tx_load        = 1'b1;
                next_flags.transmit_in_progress = 1'b1;        // [R2]
            end
        end
        // ACK slot over: record result and end the transmit
        if (ack_done && flags.transmit_in_progress) begin
            next_flags.ack_result_flag      = ack_seen;        // [R1]
            next_flags.transmit_in_progress = 1'b0;            // [R2]
        end
        if (collision_in && master_op_in) begin
            next_flags.bus_collision_flag = 1'b1;              // [R4]
        end
        // Stop clears match flags; a match in the same cycle wins
        if (stop_det) begin
            next_flags.general_call_flag  = 1'b0;              // [R5]
            next_flags.ten_bit_match_flag = 1'b0;              // [R6]
        end
        if (gen_call_match_in) next_flags.general_call_flag  = 1'b1; // [R5]
        if (ten_bit_match_in)  next_flags.ten_bit_match_flag = 1'b1; // [R6]
        if (addr_match_in)     next_flags.data_not_addr      = 1'b0; // [R9]
        if (slave_data_rx_in)  next_flags.data_not_addr      = 1'b1; // [R9]
        if (start_det)         next_flags.stop_last          = 1'b0; // [R10]
        if (stop_det)          next_flags.stop_last          = 1'b1; // [R10]
        // Move shift byte to holding; a full holding keeps the old byte
        if (rx_xfer_in) begin
            if (next_rx_full) begin
                next_flags.receive_overflow_flag = 1'b1;       // [R8]
            end else begin
                next_rx_holding_reg = rx_shift_reg_in;
                next_rx_full        = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            flags          <= FLAGS_RST;                       // [R11]
            tx_holding_reg <= BYTE_RST;
            rx_holding_reg <= BYTE_RST;
            rx_full        <= 1'b0;
            tx_load_out    <= 1'b0;
        end else begin
            flags          <= next_flags;
            tx_holding_reg <= next_tx_holding_reg;
            rx_holding_reg <= next_rx_holding_reg;
            rx_full        <= next_rx_full;
            tx_load_out    <= next_tx_load;
        end
    end

    assign tx_data_out = tx_holding_reg;

    // Interrupt events are rising edges of the two collision flags and the overflow flag, plus ACK and Stop
    always_comb begin
        events          = '0;
        events[EV_ACK]  = ack_done & flags.transmit_in_progress;
        events[EV_BCL]  = next_flags.bus_collision_flag & ~flags.bus_collision_flag;
        events[EV_WCOL] = next_flags.write_collision_flag & ~flags.write_collision_flag;
        events[EV_OVF]  = next_flags.receive_overflow_flag & ~flags.receive_overflow_flag;
        events[EV_STOP] = stop_det;
        next_irq_stat   = irq_stat;
        next_irq_en     = irq_en;
        if (wr_data && wr_addr == IRQ_CL_OFS) begin
            next_irq_stat = irq_stat & ~hwdata_in[EV_W-1:0];
        end
        if (wr_data && wr_addr == IRQ_EN_OFS) begin
            next_irq_en = hwdata_in[EV_W-1:0];
        end
        next_irq_stat = next_irq_stat | events;          // Set beats clear
        next_irq      = |(next_irq_stat & next_irq_en);
    end

    // Bus response and interrupt registers
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            irq_stat      <= IRQ_RST;
            irq_en        <= IRQ_RST;
            irq_out       <= 1'b0;
            wr_pend       <= 1'b0;
            wr_addr       <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            irq_stat      <= next_irq_stat;
            irq_en        <= next_irq_en;
            irq_out       <= next_irq;
            wr_pend       <= next_wr_pend;
            wr_addr       <= next_wr_addr;
            hrdata_out    <= next_hrdata;
            hreadyout_out <= 1'b1;                         // Never stalls
            hresp_out     <= 1'b0;                         // Always OKAY
        end
    end

    // Width is fixed at a word; size is accepted but not checked
    logic unused_ok;
    assign unused_ok = ^{hsize_in, haddr_in[31:8], hwdata_in[31:16]};

endmodule // isf_status
`default_nettype wire

// *** dv/isf_status_props.sv ***
// Checker for the status-flag block, bound to its top-level ports.
// Assumes zero-wait AHB-Lite replies and a one-clock transmit strobe.
`timescale 1ns/1ps
`default_nettype none
module isf_status_props
    import isf_pkg::*;
(
    // Watched ports
    input wire logic        core_clk_in,
    input wire logic        srst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic        engine_busy_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic [7:0]  tx_data_out,
    input wire logic        tx_load_out,
    input wire logic        irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    logic rd_ph, next_rd_ph; // Read data phase
    logic tx_ph, next_tx_ph; // Transmit write data phase
    wire logic take = hsel_in && htrans_in[1] && hready_in; // Address phase taken
    // Phase trackers, so read data and strobes can be tied to their request
    always_comb begin
        next_rd_ph = take && !hwrite_in;
        next_tx_ph = take && hwrite_in && (haddr_in[7:0] == TXH_OFS);
    end
    always_ff @(posedge core_clk_in) begin
        rd_ph <= next_rd_ph;
        tx_ph <= next_tx_ph;
    end
    sequence s_tx_addr;
        take && hwrite_in && (haddr_in[7:0] == TXH_OFS);
    endsequence
    sequence s_busy_data;
        s_tx_addr ##1 engine_busy_in;
    endsequence
    a_reset_quiet: assert property ($past(srst_in) |-> hrdata_out == 32'h0 && !irq_out && !tx_load_out)
        else $error("outputs not quiet after reset");
    a_unimpl_zero: assert property (hrdata_out[13:11] == 3'h0)
        else $error("unimplemented status bits not zero");
    a_read_idle: assert property (!rd_ph |-> hrdata_out == 32'h0)
        else $error("read data outside a read data phase");
    a_load_pulse: assert property (tx_load_out |=> !tx_load_out)
        else $error("transmit strobe longer than one clock");
    a_load_cause: assert property (tx_load_out |-> $past(tx_ph) || $past(tx_ph, 2))
        else $error("transmit strobe without a transmit write");
    a_busy_refuse: assert property (s_busy_data |-> !tx_load_out [*3])
        else $error("transmit write accepted while busy");
    a_byte_hold: assert property ($changed(tx_data_out) |-> ##[0:1] (tx_load_out || $past(tx_load_out)))
        else $error("transmit byte changed without a load");
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("slave not ready or not okay");
endmodule // isf_status_props
bind isf_status isf_status_props u_props (.*);
`default_nettype wire

// *** dv/isf_bus_partner.sv ***
// Far side of the two-wire bus: another master or slave making frames.
// Assumes pull-ups, so released lines read high; clock idles outside frames.
`timescale 1ns/1ps
`default_nettype none
module isf_bus_partner #(
    parameter int HALF_NS = 160 // Half of the 320 ns link period
) (
    // Bus lines seen by the block
    output logic scl_out,
    output logic sda_out
);
    // Idle bus, both lines pulled high
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // Start: data falls while clock high; the 7 ns skews phase off the core clock
    task automatic bus_start();
        #7 sda_out = 1'b0;
        #HALF_NS scl_out = 1'b0;
        #HALF_NS;
    endtask
    // Stop: data rises while clock high, then the clock stands still
    task automatic bus_stop();
        #7 sda_out = 1'b0;
        #HALF_NS scl_out = 1'b1;
        #HALF_NS sda_out = 1'b1;
        #HALF_NS;
    endtask
    // Eight data bits then the slave's acknowledge; data changes only while clock low
    task automatic clock_byte(input logic [7:0] b, input logic nack);
        #7;
        for (int i = 0; i < 9; i++) begin
            sda_out = (i < 8) ? b[7-i] : nack;
            #HALF_NS scl_out = 1'b1;
            #HALF_NS scl_out = 1'b0;
        end
        sda_out = 1'b1; // Released, pull-up wins
        #HALF_NS;
    endtask
endmodule // isf_bus_partner
`default_nettype wire

// *** dv/isf_status_tb.sv ***
// Self-checking bench for the status-flag block: AHB-Lite master tasks,
// engine event pulses and a bus partner; one task per scenario.
`timescale 1ns/1ps
`default_nettype none
module isf_status_tb
    import isf_pkg::*;
;
    logic        core_clk_in = 1'b0;    // 25 MHz core clock
    logic        srst_in = 1'b1;        // Sync reset
    logic [31:0] haddr_in = '0;         // Bus request
    logic [31:0] hwdata_in = '0;
    logic [1:0]  htrans_in = '0;
    logic        hwrite_in = 1'b0;
    logic        engine_busy_in = 1'b0; // Engine levels
    logic        master_op_in = 1'b0;
    logic [5:0]  ev = '0;               // Engine pulses
    logic [7:0]  rx_shift_reg_in = '0;
    logic [31:0] hrdata_out;            // Block outputs
    logic [7:0]  tx_data_out;
    logic        hreadyout_out, hresp_out, tx_load_out, irq_out;
    wire logic   scl_in, sda_in;        // Bus pins from the partner
    int          fail_count = 0, n_checks = 0, cyc = 0, loads = 0;
    isf_status u_dut (.*, .hsel_in(1'b1), .hsize_in(3'h2), .hready_in(hreadyout_out),
        .collision_in(ev[0]), .gen_call_match_in(ev[1]), .ten_bit_match_in(ev[2]),
        .addr_match_in(ev[3]), .slave_data_rx_in(ev[4]), .rx_xfer_in(ev[5]));
    isf_bus_partner u_bus (.scl_out(scl_in), .sda_out(sda_in));
    initial begin
        forever #20 core_clk_in = ~core_clk_in;
    end
    // Cycle ceiling and strobe counter; a hang counts as a mismatch
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (tx_load_out === 1'b1) loads <= loads + 1;
        if (cyc == 4000) begin
            fail_count++;
            final_report;
        end
    end
    function automatic logic [31:0] fb(input int p);
        return 32'h1 << p;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    // One single transfer; waits on hready in both phases, never counts on latency
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk_in);
        haddr_in  <= {24'h0, a};
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        @(posedge core_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge core_clk_in);
        htrans_in <= 2'b00;
        hwdata_in <= wd;
        @(posedge core_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge core_clk_in);
        rd = hrdata_out;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(what, d, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge core_clk_in);
        ev[i] <= 1'b1;
        @(posedge core_clk_in);
        ev[i] <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic t_reset;
        rc(STAT_OFS, 32'h0, "status");
        rc(IRQ_ST_OFS, 32'h0, "events");
        rc(8'h20, 32'h0, "unmapped");
        $display("reset test done");
    endtask
    // NACK then ACK from the slave; progress flag spans the byte and its acknowledge
    task automatic t_master_tx;
        logic [31:0] prev;
        prev = 32'h0;
        for (int k = 0; k < 2; k++) begin
            u_bus.bus_start();
            wr(TXH_OFS, 32'ha5 ^ k);
            idle(2);
            chk("tx byte", {24'h0, tx_data_out}, 32'ha5 ^ k);
            chk("loads", loads, k + 1);
            rc(STAT_OFS, prev | fb(TIP_POS), "in progress");
            u_bus.clock_byte(8'h5a, k == 0);
            idle(4);
            prev = (k == 0) ? fb(ACK_POS) : 32'h0;
            rc(STAT_OFS, prev, "ack result");
            rc(IRQ_ST_OFS, fb(EV_ACK), "ack event");
            u_bus.bus_stop();
            wr(IRQ_CL_OFS, 32'h1f);
        end
        $display("master transmit test done");
    endtask
    task automatic t_wcol;
        @(posedge core_clk_in);
        engine_busy_in <= 1'b1;
        wr(TXH_OFS, 32'h3c);
        idle(3);
        chk("refused", loads, 2);
        chk("byte kept", {24'h0, tx_data_out}, 32'ha4);
        @(posedge core_clk_in);
        engine_busy_in <= 1'b0;
        idle(20);
        rc(STAT_OFS, fb(WCOL_POS) | fb(STP_POS), "wcol sticky");
        wr(STAT_OFS, fb(WCOL_POS));
        rc(STAT_OFS, fb(STP_POS), "wcol cleared");
        $display("write collision test done");
    endtask
    task automatic t_irq;
        pulse(0);
        idle(2);
        rc(STAT_OFS, fb(STP_POS), "no master op");
        @(posedge core_clk_in);
        master_op_in <= 1'b1;
        pulse(0);
        rc(STAT_OFS, fb(BCL_POS) | fb(STP_POS), "collision");
        idle(2);
        chk("irq masked", irq_out, 1'b0);
        wr(IRQ_EN_OFS, fb(EV_BCL));
        idle(2);
        chk("irq raised", irq_out, 1'b1);
        rc(IRQ_EN_OFS, fb(EV_BCL), "enable readback");
        wr(IRQ_CL_OFS, fb(EV_BCL));
        idle(2);
        chk("irq cleared", irq_out, 1'b0);
        wr(STAT_OFS, fb(BCL_POS));
        rc(STAT_OFS, fb(STP_POS), "bcl cleared");
        master_op_in <= 1'b0;
        $display("collision and interrupt test done");
    endtask
    task automatic t_slave;
        pulse(1);
        pulse(2);
        pulse(3);
        rc(STAT_OFS, fb(GC_POS) | fb(T10_POS) | fb(STP_POS), "matches");
        pulse(4);
        rc(STAT_OFS, fb(GC_POS) | fb(T10_POS) | fb(STP_POS) | fb(DA_POS), "data");
        u_bus.bus_start();
        idle(6);
        rc(STAT_OFS, fb(GC_POS) | fb(T10_POS) | fb(DA_POS), "start");
        u_bus.bus_stop();
        idle(6);
        rc(STAT_OFS, fb(DA_POS) | fb(STP_POS), "stop");
        // Data flag is set here, so an address match must visibly clear it
        pulse(3);
        rc(STAT_OFS, fb(STP_POS), "address clears");
        $display("slave flags test done");
    endtask
    task automatic t_overflow;
        @(posedge core_clk_in);
        rx_shift_reg_in <= 8'h61;
        pulse(5);
        rx_shift_reg_in <= 8'h62;
        pulse(5);
        rc(STAT_OFS, fb(OVF_POS) | fb(STP_POS), "overflow");
        rc(RXH_OFS, 32'h61, "first kept");
        wr(STAT_OFS, fb(OVF_POS));
        rc(STAT_OFS, fb(STP_POS), "ovf cleared");
        $display("overflow test done");
    endtask
    // Sticky events left by earlier tests, then a reset in mid-run wipes all state
    task automatic t_midreset;
        rc(IRQ_ST_OFS, fb(EV_WCOL) | fb(EV_OVF) | fb(EV_STOP), "sticky events");
        @(posedge core_clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        srst_in <= 1'b0;
        rc(STAT_OFS, 32'h0, "status after reset");
        rc(IRQ_ST_OFS, 32'h0, "events after reset");
        rc(IRQ_EN_OFS, 32'h0, "enables after reset");
        chk("tx after reset", {24'h0, tx_data_out}, 32'h0);
        $display("mid-run reset test done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        srst_in <= 1'b0;
        idle(3);
        t_reset;
        t_master_tx;
        t_wcol;
        t_irq;
        t_slave;
        t_overflow;
        t_midreset;
        final_report;
    end
endmodule // isf_status_tb
`default_nettype wire
